// File: rtl/adc_calibration_sequencer.sv
// calibration sequencer: steers modulator source, counts output periods,
// loads coefficients and drives the active-low data-ready output
// assumes the control word and modulator results arrive on clk_in
// Behaviour
// [R01] mode 001 starts self calibration on shorted inputs and reference
// [R02] self calibration converts shorted node first, then reference node
// [R03] data ready falls only after coefficients load and filter resettles
// [R04] self calibration uses the currently selected gain setting
// [R05] bipolar range calibrates midscale and positive full scale
// [R06] mode 010 takes zero scale from the selected analog input
// [R07] mode 011 takes full scale from the selected analog input
// [R08] each system calibration step ends with data ready low
// [R09] host holds calibration voltage steady through each system step
// [R10] repeating zero step alone changes offset, keeps slope
// [R11] mode 100 converts input for zero, reference for span
// [R12] system offset calibration is one step ending with data ready low
// [R13] mode 101 interleaves calibration conversions and updates continually
// [R14] background mode cuts output rate by six, bandwidth kept
// [R15] background mode stays until mode bits change
// [R16] first background result invalid; second after step settles
// [R17] nine, four per step, or six output periods until valid data; background data is valid from the second stretched word
// [R18] power-up reset puts control bits in known default
// [R19] host calibrates after power-up once reference settles
// [R20] host uses high level input only in unipolar range
// [R21] any calibration command resets the digital filter
// [R22] offset subtracted from result before gain multiply
// [R23] host ignores data ready one modulator cycle after command
// [R24] other mode codes start nothing and keep coefficients
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_sequencer (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control word write (three mode bits, gain, polarity) and output period length
    input wire logic ctrl_write_in,
    input wire logic cal_mode_bit2_in,
    input wire logic cal_mode_bit1_in,
    input wire logic cal_mode_bit0_in,
    input wire logic [2:0] gain_sel_in,
    input wire logic bipolar_in,
    input wire logic [15:0] period_m1_in,
    // modulator result
    input wire logic [23:0] conv_result_in,
    // result read completion (last bit shifted out)
    input wire logic result_read_in,
    // modulator steering and status
    output logic [1:0] mod_source_out,
    output logic [2:0] mod_gain_out,
    output logic filter_reset_out,
    output logic data_ready_n_out,
    output logic [23:0] data_out,
    output logic [2:0] cal_mode_out,
    output logic cal_busy_out,
    output logic result_valid_out,
    output logic [23:0] offset_coef_out,
    output logic [23:0] gain_coef_out
);
    import cal_seq_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ZERO,
        ST_FULL,
        ST_LOAD,
        ST_SETTLE,
        ST_RUN
    } cal_state_e;

    cal_state_e state;
    logic [2:0] mode;
    logic [2:0] gain_sel;
    logic bipolar;
    logic [3:0] count;
    logic [3:0] limit;
    logic [2:0] bg_slot;
    logic bg_first;
    logic filt_rst;
    logic mod_tick;
    logic out_tick;
    logic [15:0] period_m1;
    logic [23:0] corrected;
    logic [23:0] zero_sample;
    logic [23:0] full_sample;
    logic load_offset;
    logic load_gain;
    logic [2:0] next_mode;
    logic cal_cmd;
    logic new_word;
    cal_coef_if coef ();

    ////////////////////////////////////////////////////////////////////////
    // command decode; only the five listed codes start a sequence
    assign next_mode = {cal_mode_bit2_in, cal_mode_bit1_in, cal_mode_bit0_in};
    assign cal_cmd = ctrl_write_in && ((next_mode == MODE_SELF) // R24
        || (next_mode == MODE_SYS_ZERO) || (next_mode == MODE_SYS_FULL)
        || (next_mode == MODE_SYS_OFFSET) || (next_mode == MODE_BACKGROUND));

    // control register; reset gives a known default
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mode <= MODE_RESET; // R18
            gain_sel <= 3'h0;
            bipolar <= GAIN_RESET;
        end else if (ctrl_write_in) begin
            mode <= next_mode; // R15
            gain_sel <= gain_sel_in;
            bipolar <= bipolar_in;
        end
    end

    // background mode stretches the output period by the rate factor
    always_comb begin
        period_m1 = period_m1_in;
        if (mode == MODE_BACKGROUND) begin
            period_m1 = 16'((32'(period_m1_in) + 32'h1) * 32'(BG_RATE_FACTOR) - 32'h1); // R14
        end
    end

    // filter reset on any calibration command
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            filt_rst <= 1'b0;
        end else begin
            filt_rst <= cal_cmd; // R21
        end
    end

    mod_rate_div u_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .restart_in(filt_rst),
        .period_m1_in(period_m1),
        .mod_tick_out(mod_tick),
        .out_tick_out(out_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequence state; duration counted in output periods
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            count <= 4'h0;
            limit <= 4'h0;
        end else if (cal_cmd) begin
            count <= 4'h0;
            case (next_mode)
                MODE_SELF, MODE_SYS_OFFSET: begin
                    state <= ST_ZERO; // R01 R11
                    limit <= PERIODS_SELF; // R17
                end
                MODE_SYS_ZERO: begin
                    state <= ST_ZERO; // R06
                    limit <= PERIODS_SYS_STEP; // R17
                end
                MODE_SYS_FULL: begin
                    state <= ST_FULL; // R07
                    limit <= PERIODS_SYS_STEP; // R17
                end
                MODE_BACKGROUND: begin
                    state <= ST_RUN; // R13
                    limit <= PERIODS_BACKGROUND; // R17
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end else if (ctrl_write_in) begin
            state <= ST_IDLE; // leaving background on a mode change
        end else if (out_tick) begin
            count <= count + 4'h1;
            case (state)
                ST_ZERO: begin
                    // two-point modes go on to the full conversion; lone zero step loads
                    if (mode == MODE_SYS_ZERO) begin
                        state <= ST_LOAD;
                    end else if (count + 4'h1 >= SLOT_FULL) begin
                        state <= ST_FULL; // R02
                    end
                end
                ST_FULL: begin
                    if (mode == MODE_SYS_FULL || count + 4'h1 >= SLOT_FULL + SLOT_FULL) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    state <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (count + 4'h1 >= limit) begin
                        state <= ST_IDLE; // R03
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // source steering: input or internal nodes by mode and phase
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mod_source_out <= SRC_INPUT;
        end else if (state == ST_ZERO) begin
            mod_source_out <= (mode == MODE_SELF) ? SRC_SHORTED : SRC_INPUT; // R02
        end else if (state == ST_FULL) begin
            mod_source_out <= (mode == MODE_SYS_FULL) ? SRC_INPUT : SRC_REFERENCE;
        end else if (state == ST_RUN && bg_slot == 3'h4) begin
            mod_source_out <= SRC_SHORTED; // R13
        end else if (state == ST_RUN && bg_slot == 3'h5) begin
            mod_source_out <= SRC_REFERENCE; // R13
        end else begin
            mod_source_out <= SRC_INPUT;
        end
    end

    // calibration runs at the selected gain
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mod_gain_out <= 3'h0;
        end else begin
            mod_gain_out <= gain_sel; // R04
        end
    end

    // background slot counter: six slots of one modulator cycle each, slots 4 and 5 calibrate
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || cal_cmd) begin
            bg_slot <= 3'h0;
        end else if (state == ST_RUN && mod_tick) begin
            bg_slot <= (bg_slot == BG_RATE_FACTOR - 3'h1) ? 3'h0 : bg_slot + 3'h1;
        end
    end

    // capture calibration samples; bipolar zero point sits at midscale
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            zero_sample <= OFFSET_RESET;
            full_sample <= GAIN_COEF_RESET;
        end else if (out_tick && state == ST_ZERO) begin
            zero_sample <= bipolar ? conv_result_in - MIDSCALE : conv_result_in; // R05
        end else if (out_tick && state == ST_FULL) begin
            full_sample <= conv_result_in;
        end else if (mod_tick && state == ST_RUN && bg_slot == 3'h4) begin
            zero_sample <= bipolar ? conv_result_in - MIDSCALE : conv_result_in; // R05
        end else if (mod_tick && state == ST_RUN && bg_slot == 3'h5) begin
            full_sample <= conv_result_in;
        end
    end

    // coefficient load pulses; the zero step alone never touches gain
    always_comb begin
        load_offset = 1'b0;
        load_gain = 1'b0;
        if (out_tick && state == ST_LOAD) begin
            load_offset = (mode != MODE_SYS_FULL); // R10
            load_gain = (mode != MODE_SYS_ZERO); // R10
        end else if (mod_tick && state == ST_RUN && bg_slot == 3'h0 && !bg_first) begin
            load_offset = 1'b1; // R13
            load_gain = 1'b1; // R13
        end
    end

    assign coef.load_offset = load_offset;
    assign coef.load_gain = load_gain;
    assign coef.zero_sample = zero_sample;
    assign coef.full_sample = full_sample;

    cal_coef_store u_store (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .coef(coef.store),
        .raw_in(conv_result_in),
        .corrected_out(corrected)
    );

    ////////////////////////////////////////////////////////////////////////
    // first background result is marked invalid
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || cal_cmd) begin
            bg_first <= 1'b1;
        end else if (state == ST_RUN && out_tick) begin
            bg_first <= 1'b0; // R16
        end
    end

    // new output word: normal periods, or every background word including the first
    assign new_word = out_tick && (state == ST_IDLE || state == ST_RUN);

    // data ready: raised on command or read, low once a valid word lands; command beats a landing word, a landing word beats a read
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_ready_n_out <= 1'b1;
        end else if (cal_cmd) begin
            data_ready_n_out <= 1'b1; // R23
        end else if (out_tick && state == ST_SETTLE && count + 4'h1 >= limit) begin
            data_ready_n_out <= 1'b0; // R03 R08 R12
        end else if (new_word && !(state == ST_RUN && bg_first)) begin
            data_ready_n_out <= 1'b0; // R16
        end else if (result_read_in) begin
            data_ready_n_out <= 1'b1;
        end
    end

    // output word register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_out <= 24'h000000;
            result_valid_out <= 1'b0;
        end else if (new_word) begin
            data_out <= corrected;
            result_valid_out <= !(state == ST_RUN && bg_first); // R16
        end
    end

    // status mirrors
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cal_mode_out <= MODE_RESET;
            cal_busy_out <= 1'b0;
            filter_reset_out <= 1'b0;
            offset_coef_out <= OFFSET_RESET;
            gain_coef_out <= GAIN_COEF_RESET;
        end else begin
            cal_mode_out <= mode;
            cal_busy_out <= (state != ST_IDLE) && (state != ST_RUN);
            filter_reset_out <= filt_rst;
            offset_coef_out <= coef.offset_coef;
            gain_coef_out <= coef.gain_coef;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_cmd_self;
        cal_cmd && next_mode == MODE_SELF;
    endsequence

    a_cmd_filter_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cal_cmd |=> filter_reset_out == 1'b0 ##1 filter_reset_out) // R21
        else $error("filter not reset after calibration command");
    a_self_shorted: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_cmd_self ##1 !ctrl_write_in |=> state == ST_ZERO) // R01
        else $error("self calibration did not start");
    a_bad_code_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ctrl_write_in && !cal_cmd |=> state == ST_IDLE && !load_offset) // R24
        else $error("unlisted code started calibration");
    a_zero_keeps_gain: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        mode == MODE_SYS_ZERO && state != ST_RUN |-> !load_gain) // R10
        else $error("zero step altered slope");
    a_ready_high_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        cal_cmd |=> data_ready_n_out) // R23
        else $error("data ready not raised by command");
    a_ready_after_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $fell(data_ready_n_out) && $past(cal_busy_out) |-> $past(state) == ST_SETTLE) // R03
        else $error("data ready fell before settle");
    a_bg_first_bad: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        new_word && state == ST_RUN && bg_first |=> !result_valid_out) // R16
        else $error("first background word marked valid");
    a_bg_stays: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state == ST_RUN && !ctrl_write_in |=> state == ST_RUN) // R15
        else $error("background mode left without write");
    a_gain_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ##1 mod_gain_out == $past(gain_sel)) // R04
        else $error("calibration gain not the selected gain");
endmodule : adc_calibration_sequencer
`default_nettype wire

// File: include/cal_seq_pkg.sv
// package for the calibration sequencer: mode codes, input selects, timing counts
// assumes a 125 MHz system clock; modulator cycle enable comes from a divider
package cal_seq_pkg;
    // calibration mode field codes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SELF = 3'h1;
    localparam logic [2:0] MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] MODE_SYS_OFFSET = 3'h4;
    localparam logic [2:0] MODE_BACKGROUND = 3'h5;
    // modulator source select codes
    localparam logic [1:0] SRC_INPUT = 2'h0;
    localparam logic [1:0] SRC_SHORTED = 2'h1;
    localparam logic [1:0] SRC_REFERENCE = 2'h2;
    // control register default after power-up reset
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic GAIN_RESET = 1'b0;
    // durations in output periods until valid data
    localparam logic [3:0] PERIODS_SELF = 4'h9;
    localparam logic [3:0] PERIODS_SYS_STEP = 4'h4;
    localparam logic [3:0] PERIODS_BACKGROUND = 4'h6;
    // background calibration slows output by this factor
    localparam logic [2:0] BG_RATE_FACTOR = 3'h6;
    // conversion slots used by the zero and full conversions
    localparam logic [3:0] SLOT_FULL = 4'h3;
    // master clock divider to modulator rate (one modulator cycle)
    localparam int CLK_PERIOD_NS = 8;
    localparam int MOD_PERIOD_NS = 256;
    localparam int MOD_DIV = MOD_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] MOD_DIV_M1 = 8'(MOD_DIV - 1);
    // coefficient widths
    localparam int DATA_W = 24;
    localparam logic [23:0] OFFSET_RESET = 24'h000000;
    localparam logic [23:0] GAIN_COEF_RESET = 24'h800000;
    localparam logic [23:0] MIDSCALE = 24'h800000;
endpackage : cal_seq_pkg

// File: include/cal_coef_if.sv
// interface carrying coefficient updates from sequencer to coefficient store
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface cal_coef_if;
    logic load_offset;
    logic load_gain;
    logic [23:0] zero_sample;
    logic [23:0] full_sample;
    logic [23:0] offset_coef;
    logic [23:0] gain_coef;
    modport seq (output load_offset, output load_gain, output zero_sample,
                 output full_sample, input offset_coef, input gain_coef);
    modport store (input load_offset, input load_gain, input zero_sample,
                   input full_sample, output offset_coef, output gain_coef);
endinterface : cal_coef_if
`default_nettype wire

// File: rtl/cal_coef_store.sv
// offset and gain coefficient registers with correction datapath
// assumes load pulses come from the sequencer on the same clock
`timescale 1ns/1ps
`default_nettype none
module cal_coef_store (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // coefficient carrier
    cal_coef_if.store coef,
    // correction datapath
    input wire logic [23:0] raw_in,
    output logic [23:0] corrected_out
);
    import cal_seq_pkg::*;
    logic [23:0] offset;
    logic [23:0] gain;
    logic [23:0] diff;
    logic [47:0] prod;

    ////////////////////////////////////////////////////////////////////////
    // offset reload leaves the gain alone, so a lone zero step keeps slope
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            offset <= OFFSET_RESET;
        end else if (coef.load_offset) begin
            offset <= coef.zero_sample; // R10
        end
    end

    // span from full minus zero; zero span keeps the old value
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            gain <= GAIN_COEF_RESET;
        end else if (coef.load_gain && (coef.full_sample != coef.zero_sample)) begin
            gain <= coef.full_sample - coef.zero_sample;
        end
    end

    assign coef.offset_coef = offset;
    assign coef.gain_coef = gain;

    // subtract first, multiply after
    assign diff = raw_in - offset; // R22
    assign prod = diff * gain; // R22
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            corrected_out <= 24'h000000;
        end else begin
            corrected_out <= prod[46:23];
        end
    end
endmodule : cal_coef_store
`default_nettype wire

// File: rtl/mod_rate_div.sv
// divider giving a one-cycle enable per modulator cycle and per output period
// assumes a single clock; output period length is a port
`timescale 1ns/1ps
`default_nettype none
module mod_rate_div (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // restart both counters (filter reset)
    input wire logic restart_in,
    // modulator cycles per output period, minus one
    input wire logic [15:0] period_m1_in,
    // enables
    output logic mod_tick_out,
    output logic out_tick_out
);
    import cal_seq_pkg::*;
    logic [7:0] div;
    logic [15:0] per;

    ////////////////////////////////////////////////////////////////////////
    // modulator cycle enable
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || restart_in) begin
            div <= 8'h00;
            mod_tick_out <= 1'b0;
        end else begin
            mod_tick_out <= (div == MOD_DIV_M1);
            div <= (div == MOD_DIV_M1) ? 8'h00 : div + 8'h01;
        end
    end

    // output period enable counted in modulator cycles
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || restart_in) begin
            per <= 16'h0000;
            out_tick_out <= 1'b0;
        end else if (mod_tick_out) begin
            out_tick_out <= (per >= period_m1_in);
            per <= (per >= period_m1_in) ? 16'h0000 : per + 16'h0001;
        end else begin
            out_tick_out <= 1'b0;
        end
    end
endmodule : mod_rate_div
`default_nettype wire

// File: test/cal_host_model.sv
// far-side model: host-held analog levels and internal nodes seen by the modulator
// assumes the bench applies the host input level and holds it through each step
`timescale 1ns/1ps
`default_nettype none
module cal_host_model
    import cal_seq_pkg::*;
#(
    parameter logic [23:0] SHORT_LVL = 24'h000123,
    parameter logic [23:0] REF_LVL = 24'h6a0000
) (
    // steering from the sequencer
    input wire logic [1:0] source_in,
    // level the host applies to the selected input
    input wire logic [23:0] level_in,
    // filtered modulator word
    output logic [23:0] result_out
);
    // host keeps the calibration voltage steady; unused code reads inverted input
    always_comb begin
        case (source_in)
            SRC_SHORTED: result_out = SHORT_LVL;
            SRC_REFERENCE: result_out = REF_LVL;
            SRC_INPUT: result_out = level_in;
            default: result_out = ~level_in;
        endcase
    end
endmodule // cal_host_model
`default_nettype wire

// File: test/test_adc_calibration_sequencer.sv
// bench for the calibration sequencer: mode writes, waits and coefficient compares
// assumes the host model above and a period of one modulator cycle per word
`timescale 1ns/1ps
`default_nettype none
module test_adc_calibration_sequencer;
    import cal_seq_pkg::*;
    localparam logic [23:0] SL = 24'h000123;
    localparam logic [23:0] RL = 24'h6a0000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [2:0] gsel = 3'h3;
    logic [23:0] vin = 24'h000000;
    logic [23:0] conv, dout, ofs, gc;
    logic [1:0] src;
    logic [2:0] mgain, cmode;
    logic frst, data_ready_n_n, busy, valid;
    logic [2:0] bad_codes [3] = '{3'h6, 3'h7, 3'h0};
    time t_short, t_ref;
    logic frst_seen;
    int checks = 0;
    int miscompares = 0;
    always #4 clk = ~clk;
    adc_calibration_sequencer i_adc_calibration_sequencer (.clk_in(clk), .rst_n_in(rst_n),
        .ctrl_write_in(wr), .cal_mode_bit2_in(mode[2]), .cal_mode_bit1_in(mode[1]),
        .cal_mode_bit0_in(mode[0]), .gain_sel_in(gsel), .bipolar_in(1'b0),
        .period_m1_in(16'h0000), .conv_result_in(conv), .result_read_in(rd),
        .mod_source_out(src), .mod_gain_out(mgain), .filter_reset_out(frst),
        .data_ready_n_out(data_ready_n_n), .data_out(dout), .cal_mode_out(cmode),
        .cal_busy_out(busy), .result_valid_out(valid), .offset_coef_out(ofs),
        .gain_coef_out(gc));
    cal_host_model #(.SHORT_LVL(SL), .REF_LVL(RL)) i_cal_host_model (.source_in(src),
        .level_in(vin), .result_out(conv));
    ////////////////////////////////////////////////////////////////////////////////
    // order of conversions and filter restart, cleared at every command
    always @(posedge clk) begin
        if (wr) begin
            t_short = 0;
            t_ref = 0;
            frst_seen = 1'b0;
        end else begin
            if (src === SRC_SHORTED && t_short == 0) t_short = $time;
            if (src === SRC_REFERENCE && t_ref == 0) t_ref = $time;
            if (frst === 1'b1) frst_seen = 1'b1;
        end
    end
    // wide enough for two packed coefficients
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmd(input logic [2:0] code);
        @(posedge clk);
        wr <= 1'b1;
        mode <= code;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // bounded wait for data ready; duration must land in the last period of the count
    task automatic wait_ready(input int periods);
        int n;
        n = 0;
        // data ready is ignored for the command edge itself
        @(negedge clk);
        while (data_ready_n_n !== 1'b0 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) begin
            miscompares++;
            $display("ERROR at %0t: data ready never fell", $time);
            final_report();
        end
        check(24'(n >= (periods - 1) * 32 && n <= periods * 32 + 8), 24'h1, "duration");
    endtask
    task automatic read_word();
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(24'(data_ready_n_n), 24'h1, "ready after read");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({data_ready_n_n, cmode}, 4'h8, "reset state");
        check(ofs, OFFSET_RESET, "reset offset");
        check(gc, GAIN_COEF_RESET, "reset gain");
        cmd(MODE_SELF);
        @(negedge clk);
        check(24'(data_ready_n_n), 24'h1, "ready high in progress");
        wait_ready(9);
        check(24'(frst_seen), 24'h1, "filter restart");
        check(24'(t_short != 0 && t_short < t_ref), 24'h1, "shorted first");
        check({ofs, gc}, {SL, RL - SL}, "self coefficients");
        check(24'(mgain), 24'(gsel), "gain in use");
        read_word();
        $display("self calibration done");
        vin <= 24'h000400;
        cmd(MODE_SYS_ZERO);
        wait_ready(4);
        check(ofs, 24'h000400, "system zero");
        vin <= 24'h700400;
        cmd(MODE_SYS_FULL);
        wait_ready(4);
        check(gc, 24'h700000, "system full");
        vin <= 24'h000800;
        cmd(MODE_SYS_ZERO);
        wait_ready(4);
        check({ofs, gc}, {24'h000800, 24'h700000}, "zero repeat");
        $display("system calibration done");
        vin <= 24'h000200;
        cmd(MODE_SYS_OFFSET);
        wait_ready(9);
        check({ofs, gc}, {24'h000200, RL - 24'h000200}, "system offset");
        foreach (bad_codes[i]) begin
            cmd(bad_codes[i]);
            repeat (40) @(negedge clk);
            check({24'(busy), ofs}, {24'h0, 24'h000200}, "ignored code");
            check(dout, 48'h0, "input at offset reads zero");
        end
        $display("reserved codes done");
        cmd(MODE_BACKGROUND);
        // first background word lands after one stretched period and stays hidden
        repeat (200) @(negedge clk);
        check(24'(valid), 24'h0, "first word invalid");
        check(24'(data_ready_n_n), 24'h1, "no ready on first word");
        wait_ready(6);
        read_word();
        wait_ready(6);
        check({24'(valid), 21'h0, cmode}, {24'h1, 24'h5}, "background held");
        cmd(MODE_NORMAL);
        repeat (2) @(negedge clk);
        check(24'(cmode), 24'h0, "background left");
        $display("background calibration done");
        final_report();
    end
endmodule // test_adc_calibration_sequencer
`default_nettype wire
